/* File: hdl/wake_cfg_pkg.sv */
// Purpose: Shared constants for the wake and bus feature configuration block
// Assumes: 32-bit APB, one register per aligned word
// Notes: Feature-config bit positions follow the device register layout
`default_nettype none
package wake_cfg_pkg;
  localparam logic [7:0] ADDR_FEATURE_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_FIRST_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_STATION_ID_LO = 8'h08;
  localparam logic [7:0] ADDR_STATION_ID_HI = 8'h0C;
  localparam logic [7:0] ADDR_WAKE_STATUS = 8'h10;

  localparam int BIT_LINK_RESTORE_WAKE = 4;
  localparam int BIT_CARDBUS_MODE = 3;
  localparam int BIT_CLOCK_RUN = 2;
  localparam int BIT_FUNCTION_REGS = 1;
  localparam int BIT_FAST_BACK_TO_BACK = 0;

  localparam int BIT_POWER_WAKE_MASTER = 0;
  localparam int BIT_MAGIC_WAKE = 1;

  localparam int BIT_MAGIC_SEEN = 0;
  localparam int BIT_LINK_SEEN = 1;
  localparam int BIT_EVENT_ACTIVE = 2;

  localparam logic RESET_LINK_RESTORE_WAKE = 1'b0;
  localparam logic RESET_POWER_WAKE_MASTER = 1'b0;
  localparam logic RESET_MAGIC_WAKE = 1'b0;
  localparam logic [47:0] RESET_STATION_ID = 48'h0000_0000_0000;

  localparam int SYNC_RUN_BYTES = 6;
  localparam int ID_BYTES = 6;
  localparam int ID_COPIES = 16;
  localparam int STRAP_SETTLE = 3;
  localparam logic [7:0] SYNC_BYTE = 8'hFF;

  typedef enum logic [1:0] {
    hunt_sync,
    match_id,
    frame_found
  } magic_state_type;
endpackage
`default_nettype wire

/* File: hdl/magic_frame_matcher.sv */
// Purpose: Scans received bytes for a magic wake pattern
// Assumes: Bytes arrive in order on pclk, address filtering done upstream
// Notes: Reports a match only at a good frame end
`default_nettype none
module magic_frame_matcher #(
  parameter int SYNC_LEN = wake_cfg_pkg::SYNC_RUN_BYTES,
  parameter int COPIES = wake_cfg_pkg::ID_COPIES
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic [47:0] station_id, // Identifier, bits 47:40 first on wire
  input wire logic byte_valid, // Received byte strobe
  input wire logic [7:0] byte_data, // Received byte
  input wire logic frame_end, // Last byte of frame passed
  input wire logic frame_good, // Frame CRC good, with frame_end
  output logic match // One-cycle hit pulse
);
  import wake_cfg_pkg::*;

  if (SYNC_LEN < 1 || SYNC_LEN > 15 ||
      COPIES < 1 || COPIES > 31) begin : bad_counts
    $error("magic_frame_matcher: unsupported sync or copy count");
  end

  magic_state_type state;
  logic [3:0] sync_count;
  logic [2:0] id_index;
  logic [4:0] copy_count;

  function automatic logic [7:0] id_byte(input logic [47:0] id,
                                         input logic [2:0] idx);
    id_byte = id[8'(47 - 8 * int'(idx)) -: 8];
  endfunction

  wire is_sync = byte_data == SYNC_BYTE;
  wire sync_done = sync_count == 4'(SYNC_LEN);
  wire id_hit = byte_data == id_byte(station_id, id_index);
  wire first_hit = byte_data == id_byte(station_id, 3'd0);
  wire last_byte = id_index == 3'(ID_BYTES - 1);
  wire last_copy = copy_count == 5'(COPIES - 1);
  wire [3:0] restart_count = is_sync ? 4'h1 : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= hunt_sync;
      sync_count <= 4'h0;
      id_index <= 3'h0;
      copy_count <= 5'h00;
      match <= 1'b0;
    end else if (frame_end) begin
      match <= frame_good && state == frame_found;
      state <= hunt_sync;
      sync_count <= 4'h0;
      id_index <= 3'h0;
      copy_count <= 5'h00;
    end else begin
      match <= 1'b0;
      if (byte_valid) begin
        case (state)
          hunt_sync: begin
            // Sync run then first identifier byte
            if (sync_done && first_hit) begin
              state <= match_id;
              id_index <= 3'h1;
              copy_count <= 5'h00;
            end else if (is_sync) begin
              if (!sync_done) begin
                sync_count <= sync_count + 4'h1;
              end
            end else begin
              sync_count <= 4'h0;
            end
          end
          match_id: begin
            // Back-to-back copies without gaps
            if (id_hit) begin
              if (last_byte) begin
                id_index <= 3'h0;
                copy_count <= copy_count + 5'h01;
                if (last_copy) begin
                  state <= frame_found;
                end
              end else begin
                id_index <= id_index + 3'h1;
              end
            end else begin
              state <= hunt_sync;
              sync_count <= restart_count;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule // magic_frame_matcher
`default_nettype wire

/* File: hdl/wake_and_bus_feature_config.sv */
// Purpose: Wake and bus feature configuration register with APB access
// Assumes: pclk at 50 MHz, strap and link pins asynchronous to pclk
// Notes: No wait states; pready is high in the first access cycle
`default_nettype none
module wake_and_bus_feature_config (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic strap_cardbus_mode, // Strap pin
  input wire logic strap_clock_run, // Strap pin
  input wire logic strap_function_regs, // Strap pin
  input wire logic strap_fast_back_to_back, // Strap pin
  input wire logic link_up_pin, // Cable link status pin
  input wire logic power_state_ok_pin, // Power state allows wake
  input wire logic rx_byte_valid, // Received byte strobe
  input wire logic [7:0] rx_byte, // Received byte
  input wire logic rx_frame_end, // Frame end pulse
  input wire logic rx_frame_good, // CRC good with frame end
  output logic power_event_request_n, // Power event, active low
  output logic cardbus_mode_enable, // Cardbus features on
  output logic clock_run_enable, // Clock-run support on
  output logic function_regs_enable, // Function registers on
  output logic fast_back_to_back_enable // Fast back-to-back on
);
  import wake_cfg_pkg::*;

  logic [3:0] strap_meta;
  logic [3:0] strap_sync;
  logic link_meta;
  logic link_sync;
  logic link_prev;
  logic power_meta;
  logic power_sync;
  logic straps_taken;
  logic link_restore_wake_enable;
  logic power_wake_master_enable;
  logic magic_wake_enable;
  logic [47:0] station_id;
  // Wake causes, cleared by writing ones
  logic magic_seen;
  logic link_seen;
  logic magic_match;

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_meta <= 4'h0;
      strap_sync <= 4'h0;
      link_meta <= 1'b0;
      link_sync <= 1'b0;
      link_prev <= 1'b0;
      power_meta <= 1'b0;
      power_sync <= 1'b0;
    end else begin
      strap_meta <= {strap_cardbus_mode, strap_clock_run,
                     strap_function_regs, strap_fast_back_to_back};
      strap_sync <= strap_meta;
      link_meta <= link_up_pin;
      link_sync <= link_meta;
      // Previous level marks the relink edge
      link_prev <= link_sync;
      power_meta <= power_state_ok_pin;
      power_sync <= power_meta;
    end
  end

  // Straps caught once, after the synchroniser has settled
  logic [1:0] strap_delay;

  // Settle count must cover both synchroniser stages
  if (STRAP_SETTLE < 2 || STRAP_SETTLE > 3) begin : bad_settle
    $error("strap settle count does not fit the delay counter");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_delay <= 2'h0;
      straps_taken <= 1'b0;
      cardbus_mode_enable <= 1'b0;
      clock_run_enable <= 1'b0;
      function_regs_enable <= 1'b0;
      fast_back_to_back_enable <= 1'b0;
    end else if (!straps_taken) begin
      strap_delay <= strap_delay + 2'h1;
      if (strap_delay == 2'(STRAP_SETTLE)) begin
        straps_taken <= 1'b1;
        cardbus_mode_enable <= strap_sync[3];
        clock_run_enable <= strap_sync[2];
        function_regs_enable <= strap_sync[1];
        fast_back_to_back_enable <= strap_sync[0];
      end
    end
  end

  // APB decode
  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire wr = access && pwrite;
  wire hit_feature = paddr == ADDR_FEATURE_CONFIG;
  wire hit_first = paddr == ADDR_FIRST_CONFIG;
  wire hit_id_lo = paddr == ADDR_STATION_ID_LO;
  wire hit_id_hi = paddr == ADDR_STATION_ID_HI;
  wire hit_status = paddr == ADDR_WAKE_STATUS;
  wire mapped = hit_feature || hit_first || hit_id_lo || hit_id_hi ||
                hit_status;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8 * i +: 8] = strb[i] ? data[8 * i +: 8] : old[8 * i +: 8];
    end
  endfunction

  wire [31:0] feature_word = {27'h0, link_restore_wake_enable,
                              cardbus_mode_enable, clock_run_enable,
                              function_regs_enable,
                              fast_back_to_back_enable};
  wire [31:0] first_word = {30'h0, magic_wake_enable,
                            power_wake_master_enable};
  wire [31:0] status_word = {29'h0, !power_event_request_n, link_seen,
                             magic_seen};
  // Unmapped addresses read as zero
  wire [31:0] read_word =
    hit_feature ? feature_word :
    hit_first ? first_word :
    hit_id_lo ? station_id[31:0] :
    hit_id_hi ? {16'h0000, station_id[47:32]} :
    hit_status ? status_word : 32'h0000_0000;

  // Answer in the cycle after setup; idle read data stays zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? read_word : 32'h0000_0000;
    end
  end

  // Software-written controls
  // Control bits need byte lane 0; the identifier honours every lane
  wire [31:0] id_lo_new = merge(station_id[31:0], pwdata, pstrb);
  wire [31:0] id_hi_new = merge({16'h0000, station_id[47:32]}, pwdata,
                                pstrb);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_restore_wake_enable <= RESET_LINK_RESTORE_WAKE;
      power_wake_master_enable <= RESET_POWER_WAKE_MASTER;
      magic_wake_enable <= RESET_MAGIC_WAKE;
      station_id <= RESET_STATION_ID;
    end else if (wr) begin
      if (hit_feature && pstrb[0]) begin
        link_restore_wake_enable <= pwdata[BIT_LINK_RESTORE_WAKE];
      end else if (hit_first && pstrb[0]) begin
        power_wake_master_enable <= pwdata[BIT_POWER_WAKE_MASTER];
        magic_wake_enable <= pwdata[BIT_MAGIC_WAKE];
      end else if (hit_id_lo) begin
        station_id[31:0] <= id_lo_new;
      end else if (hit_id_hi) begin
        station_id[47:32] <= id_hi_new[15:0];
      end
    end
  end

  magic_frame_matcher #(
    .SYNC_LEN(SYNC_RUN_BYTES),
    .COPIES(ID_COPIES)
  ) matcher (
    .pclk(pclk),
    .presetn(presetn),
    .station_id(station_id),
    .byte_valid(rx_byte_valid),
    .byte_data(rx_byte),
    .frame_end(rx_frame_end),
    .frame_good(rx_frame_good),
    .match(magic_match)
  );

  // Wake causes; hardware set wins over software clear
  wire wake_allowed = power_wake_master_enable && power_sync;
  wire magic_set = magic_match && magic_wake_enable && wake_allowed;
  wire link_set = link_sync && !link_prev && link_restore_wake_enable &&
                  wake_allowed;
  wire clr_status = wr && hit_status && pstrb[0];
  wire clr_magic = clr_status && pwdata[BIT_MAGIC_SEEN];
  wire clr_link = clr_status && pwdata[BIT_LINK_SEEN];

  // Event output stays low while any cause is pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      magic_seen <= 1'b0;
      link_seen <= 1'b0;
      power_event_request_n <= 1'b1;
    end else begin
      magic_seen <= magic_set || (magic_seen && !clr_magic);
      link_seen <= link_set || (link_seen && !clr_link);
      power_event_request_n <= !(magic_set || link_set ||
                                 (magic_seen && !clr_magic) ||
                                 (link_seen && !clr_link));
    end
  end
endmodule // wake_and_bus_feature_config
`default_nettype wire

/* File: testbench/host_pm_model.sv */
// Purpose: Host power management, counts wake requests
// Assumes: Wake request is an active-low level
// Notes: One count per falling edge
`default_nettype none
module host_pm_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic power_event_request_n, // Wake
  output var int wake_count // Wakes seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_n <= 1'b1;
      wake_count <= 0;
    end else begin
      last_n <= power_event_request_n;
      if (last_n && !power_event_request_n) begin
        wake_count <= wake_count + 1;
      end
    end
  end
endmodule // host_pm_model
`default_nettype wire

/* File: testbench/wake_cfg_assertions.sv */
// Purpose: Port checks for the wake configuration block
// Assumes: Enables shadowed from APB writes
// Notes: Bound to the top module
`default_nettype none
module wake_cfg_assertions (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Data
  input wire logic [3:0] pstrb, // Strobes
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic link_up_pin, // Link
  input wire logic power_state_ok_pin, // Power ok
  input wire logic power_event_request_n, // Wake
  input wire logic cardbus_mode_enable, // Feature
  input wire logic clock_run_enable, // Feature
  input wire logic function_regs_enable, // Feature
  input wire logic fast_back_to_back_enable // Feature
);
  timeunit 1ns;
  timeprecision 1ns;
  import wake_cfg_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic lre;
  logic pwe;
  logic [3:0] age;
  wire wr = psel && penable && pready && pwrite && !pslverr && pstrb[0];
  wire clr = psel && penable && pwrite && paddr == ADDR_WAKE_STATUS;
  wire rd = pready && !pwrite;
  wire [3:0] feat = {cardbus_mode_enable, clock_run_enable,
    function_regs_enable, fast_back_to_back_enable};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lre <= 1'b0;
      pwe <= 1'b0;
      age <= 4'h0;
    end else begin
      if (age != 4'hF) age <= age + 4'h1;
      if (wr && paddr == ADDR_FEATURE_CONFIG) lre <= pwdata[4];
      if (wr && paddr == ADDR_FIRST_CONFIG) pwe <= pwdata[0];
    end
  end
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_in_access_a: assert property (pready |-> psel && penable &&
    $past(psel && !penable)) else $error("ready outside access");
  error_reads_zero_a: assert property (pslverr |-> pready &&
    prdata == 32'h0) else $error("bad error answer");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero");
  feature_readback_a: assert property (
    rd && paddr == ADDR_FEATURE_CONFIG |-> prdata == {27'h0, lre, feat})
    else $error("feature read wrong");
  event_bit_read_a: assert property (rd && paddr == ADDR_WAKE_STATUS |->
    prdata[2] == $past(!power_event_request_n)) else $error("event bit wrong");
  straps_hold_a: assert property (
    age == 4'hF |-> $stable(feat)) else $error("feature outputs moved");
  link_wake_a: assert property (
    $rose(link_up_pin) && lre && pwe && power_state_ok_pin &&
    power_event_request_n |-> ##[3:5] !power_event_request_n)
    else $error("no link wake");
  link_needs_master_a: assert property (
    $rose(link_up_pin) && !pwe && power_event_request_n |->
    ##1 power_event_request_n [*5]) else $error("link wake without master");
  event_holds_a: assert property (!power_event_request_n && !clr
    |=> !power_event_request_n) else $error("wake dropped early");
  cover property (wr && paddr == ADDR_WAKE_STATUS);
  cover property ($fell(power_event_request_n));
  cover property (pslverr);
endmodule // wake_cfg_assertions
bind wake_and_bus_feature_config wake_cfg_assertions wake_cfg_assertions_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .link_up_pin(link_up_pin), .power_state_ok_pin(power_state_ok_pin),
  .power_event_request_n(power_event_request_n),
  .cardbus_mode_enable(cardbus_mode_enable),
  .clock_run_enable(clock_run_enable),
  .function_regs_enable(function_regs_enable),
  .fast_back_to_back_enable(fast_back_to_back_enable));
`default_nettype wire

/* File: testbench/wake_and_bus_feature_config_tb.sv */
// Purpose: Self-checking bench for the wake configuration block
// Assumes: One answer cycle per APB transfer
// Notes: Straps and identifiers come from the bench shift register
`default_nettype none
module wake_and_bus_feature_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wake_cfg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, rx_byte;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, st;
  logic strap_cardbus_mode, strap_clock_run, strap_function_regs;
  logic strap_fast_back_to_back, link_up_pin, power_state_ok_pin;
  logic rx_byte_valid, rx_frame_end, rx_frame_good, power_event_request_n;
  logic cardbus_mode_enable, clock_run_enable, function_regs_enable;
  logic fast_back_to_back_enable;
  logic [15:0] lf;
  logic [47:0] id;
  logic [7:0] q[$];
  int bad_count, tests_run, cycles, wake_count, exp_wakes;
  wake_and_bus_feature_config wake_and_bus_feature_config_inst (.*);
  host_pm_model host_pm_model_inst (.*);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("bad_count %0d tests_run %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input int copies, input logic good);
    q = {};
    repeat (12 + lf[1:0]) begin
      lf = lfsr(lf);
      q.push_back(lf[7:0] & 8'h7F);
    end
    repeat (SYNC_RUN_BYTES) q.push_back(8'hFF);
    repeat (copies) for (int b = 5; b >= 0; b--) q.push_back(id[b*8 +: 8]);
    foreach (q[i]) begin
      @(posedge pclk);
      rx_byte_valid <= 1'b1;
      rx_byte <= q[i];
    end
    @(posedge pclk);
    rx_byte_valid <= 1'b0;
    rx_frame_end <= 1'b1;
    rx_frame_good <= good;
    @(posedge pclk);
    rx_frame_end <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, link_up_pin} = '0;
    {rx_byte_valid, rx_byte, rx_frame_end, rx_frame_good} = '0;
    pstrb = 4'hF;
    power_state_ok_pin = 1'b1;
    lf = lfsr(16'hA2F8);
    st = lf[3:0];
    {strap_cardbus_mode, strap_clock_run, strap_function_regs,
      strap_fast_back_to_back} = st;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    check({cardbus_mode_enable, clock_run_enable, function_regs_enable,
      fast_back_to_back_enable}, st);
    for (int a = 0; a < 20; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      check(rd, a == 0 ? st : 32'h0);
    end
    apb(1'b1, ADDR_FEATURE_CONFIG, 32'hFFFF_FFFF);
    apb(1'b0, ADDR_FEATURE_CONFIG, 32'h0);
    check(rd, {27'h1, st});
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    check(e, 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    check(e, 1'b1);
    check(rd, 32'h0);
    lf = lfsr(lf);
    id = {16'h1234, lf, ~lf};
    apb(1'b1, ADDR_STATION_ID_LO, id[31:0]);
    apb(1'b1, ADDR_STATION_ID_HI, {lf, id[47:32]});
    apb(1'b0, ADDR_STATION_ID_HI, 32'h0);
    check(rd, {16'h0, id[47:32]});
    pstrb <= 4'h2;
    apb(1'b1, ADDR_FEATURE_CONFIG, 32'h0);
    apb(1'b1, ADDR_STATION_ID_HI, 32'h0000_FFFF);
    pstrb <= 4'hF;
    apb(1'b0, ADDR_FEATURE_CONFIG, 32'h0);
    check(rd, {27'h1, st});
    apb(1'b0, ADDR_STATION_ID_HI, 32'h0);
    check(rd, {16'h0, 8'hFF, id[39:32]});
    apb(1'b1, ADDR_STATION_ID_HI, {16'h0, id[47:32]});
    apb(1'b0, ADDR_STATION_ID_LO, 32'h0);
    check(rd, id[31:0]);
    link_up_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    check(power_event_request_n, 1'b1);
    link_up_pin <= 1'b0;
    apb(1'b1, ADDR_FIRST_CONFIG, 32'h1);
    link_up_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    check(power_event_request_n, 1'b0);
    exp_wakes++;
    apb(1'b0, ADDR_WAKE_STATUS, 32'h0);
    check(rd, 32'h6);
    apb(1'b1, ADDR_WAKE_STATUS, 32'h2);
    @(posedge pclk);
    check(power_event_request_n, 1'b1);
    power_state_ok_pin <= 1'b0;
    link_up_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    link_up_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    check(power_event_request_n, 1'b1);
    power_state_ok_pin <= 1'b1;
    apb(1'b1, ADDR_FIRST_CONFIG, 32'h3);
    for (int k = 0; k < 3; k++) begin
      frame(k == 1 ? ID_COPIES - 1 : ID_COPIES, k != 2);
      check(power_event_request_n, k != 0);
      if (k == 0) begin
        exp_wakes++;
        apb(1'b0, ADDR_WAKE_STATUS, 32'h0);
        check(rd, 32'h5);
        apb(1'b1, ADDR_WAKE_STATUS, 32'h1);
      end
    end
    apb(1'b1, ADDR_FIRST_CONFIG, 32'h1);
    frame(ID_COPIES, 1'b1);
    check(power_event_request_n, 1'b1);
    check(wake_count, exp_wakes);
    final_report();
  end
endmodule // wake_and_bus_feature_config_tb
`default_nettype wire
